// *** rtl/umcl_defs.svh ***
// constants for the modem control line block
`ifndef UMCL_DEFS_SVH
`define UMCL_DEFS_SVH

// ==========================================
// status byte field positions
`define UMCL_MSR_DCTS_BIT 0
`define UMCL_MSR_CTS_BIT 4
`define UMCL_MSR_WIDTH 8

// ==========================================
// reset values
`define UMCL_PIN_INACTIVE 1'b1
`define UMCL_MSR_RESET 8'h00

// ==========================================
// synchroniser depth
`define UMCL_SYNC_STAGES 2

`endif

// *** rtl/umcl_pkg.sv ***
// types for the modem control line block
package umcl_pkg;
  typedef enum logic [1:0] {
    UMCL_CTS_IDLE,
    UMCL_CTS_CHANGED
  } umcl_cts_state_t;
endpackage

// *** rtl/umcl_sync.sv ***
// multi-stage level synchroniser
`timescale 1ns/1ps
`default_nettype none
module umcl_sync #(
  parameter int STAGES = 2,
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic [STAGES-1:0] chain_reg;

  // ==========================================
  // shift chain; only the last stage is seen outside
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      chain_reg <= {STAGES{RESET_VAL}};
    end else begin
      chain_reg <= {chain_reg[STAGES-2:0], async_i};
    end
  end

  assign sync_o = chain_reg[STAGES-1];
endmodule // umcl_sync
`default_nettype wire

// *** rtl/umcl_modem_lines.sv ***
// modem handshake lines: terminal ready, request to send, clear to send status
// Function
// - terminal ready pin low when bit set
// - reset forces terminal ready high
// - loopback holds terminal ready high
// - clear-to-send state shown in status bit 4
// - delta flag on change, cleared by read
// - transmitter never gated by clear-to-send
// - interrupt on change when enabled
// - request to send low means ready
`timescale 1ns/1ps
`default_nettype none
`include "umcl_defs.svh"

module umcl_modem_lines #(
  parameter int SYNC_STAGES = `UMCL_SYNC_STAGES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic dtr_bit_i,
  input wire logic rts_bit_i,
  input wire logic loopback_i,
  input wire logic msi_enable_i,
  input wire logic msr_read_i,
  input wire logic clear_to_send_in_n,
  output logic terminal_ready_out_n,
  output logic request_to_send_out_n,
  output logic [`UMCL_MSR_WIDTH-1:0] msr_o,
  output logic cts_change_irq_o
);
  // ==========================================
  // local constants and signals
  // pin slots; both output pins share one loop
  localparam int N_PINS = 2;
  localparam int PIN_DTR = 0;
  localparam int PIN_RTS = 1;

  logic [N_PINS-1:0] pin_bit;
  logic [N_PINS-1:0] pin_reg;
  logic cts_sync;
  logic cts_prev_reg;
  logic cts_change;
  logic dcts_reg;
  logic dcts_next;
  umcl_pkg::umcl_cts_state_t cts_state_reg;
  umcl_pkg::umcl_cts_state_t cts_state_next;
  logic [`UMCL_MSR_WIDTH-1:0] msr_next;
  logic pending;
  logic irq_next;

  // ==========================================
  // output pins
  // transmitter lives elsewhere and gets no gating from this block
  assign pin_bit[PIN_DTR] = dtr_bit_i;
  assign pin_bit[PIN_RTS] = rts_bit_i;

  // loopback parks both pins inactive so the modem never sees a
  // handshake while the port is talking to itself
  generate
    for (genvar g = 0; g < N_PINS; g++) begin : g_pin
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          pin_reg[g] <= `UMCL_PIN_INACTIVE;
        end else begin
          pin_reg[g] <= loopback_i | ~pin_bit[g];
        end
      end
    end
  endgenerate

  // pins leave straight from their flops, with no gate after them
  assign terminal_ready_out_n = pin_reg[PIN_DTR];
  assign request_to_send_out_n = pin_reg[PIN_RTS];

  // ==========================================
  // clear-to-send input; the modem pulls it low when ready
  // the pin is asynchronous to us, so nothing may look at it
  // before the last flop of the chain
  umcl_sync #(
    .STAGES(SYNC_STAGES),
    .RESET_VAL(`UMCL_PIN_INACTIVE)
  ) u_cts_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i(clear_to_send_in_n),
    .sync_o(cts_sync)
  );

  // previous synced level; it resets to the idle level of the pin so
  // that no false edge appears when reset lets go
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cts_prev_reg <= `UMCL_PIN_INACTIVE;
    end else begin
      cts_prev_reg <= cts_sync;
    end
  end

  assign cts_change = cts_sync ^ cts_prev_reg;

  // ==========================================
  // delta flag: a change in the read cycle wins over the clear, so a
  // change that lands on a read is still reported by the next read
  always_comb begin
    dcts_next = dcts_reg;
    if (cts_change) begin
      dcts_next = 1'b1;
    end else if (msr_read_i) begin
      dcts_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      dcts_reg <= 1'b0;
    end else begin
      dcts_reg <= dcts_next;
    end
  end

  // ==========================================
  // tracks whether a change is pending since the last read
  always_comb begin
    cts_state_next = cts_state_reg;
    case (cts_state_reg)
      umcl_pkg::UMCL_CTS_IDLE: begin
        if (cts_change) begin
          cts_state_next = umcl_pkg::UMCL_CTS_CHANGED;
        end
      end
      umcl_pkg::UMCL_CTS_CHANGED: begin
        if (msr_read_i && !cts_change) begin
          cts_state_next = umcl_pkg::UMCL_CTS_IDLE;
        end
      end
      default: begin
        cts_state_next = umcl_pkg::UMCL_CTS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cts_state_reg <= umcl_pkg::UMCL_CTS_IDLE;
    end else begin
      cts_state_reg <= cts_state_next;
    end
  end

  // ==========================================
  // status byte; unused bits read as zero
  always_comb begin
    msr_next = `UMCL_MSR_RESET;
    msr_next[`UMCL_MSR_CTS_BIT] = ~cts_sync;
    msr_next[`UMCL_MSR_DCTS_BIT] = dcts_reg;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      msr_o <= `UMCL_MSR_RESET;
    end else begin
      msr_o <= msr_next;
    end
  end

  // ==========================================
  // interrupt level follows the pending delta while enabled; a level
  // rather than a pulse, so a late enable still reports the change
  assign pending = (cts_state_reg == umcl_pkg::UMCL_CTS_CHANGED);
  assign irq_next = msi_enable_i & pending;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cts_change_irq_o <= 1'b0;
    end else begin
      cts_change_irq_o <= irq_next;
    end
  end
endmodule // umcl_modem_lines
`default_nettype wire

// *** bench/umcl_modem.sv ***
// modem side model
`timescale 1ns/1ps
`default_nettype none
module umcl_modem (
  input wire logic ref_clk_i,
  input wire logic ready_i,
  output var logic clear_to_send_in_n = 1'h1
);
  always @(posedge ref_clk_i) clear_to_send_in_n <= !ready_i;
endmodule // umcl_modem
`default_nettype wire

// *** bench/umcl_chk_asserts.sv ***
// modem line checker
`timescale 1ns/1ps
`default_nettype none
module umcl_chk (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic dtr_bit_i,
  input wire logic rts_bit_i,
  input wire logic loopback_i,
  input wire logic msi_enable_i,
  input wire logic msr_read_i,
  input wire logic clear_to_send_in_n,
  input wire logic terminal_ready_out_n,
  input wire logic request_to_send_out_n,
  input wire logic [7:0] msr_o,
  input wire logic cts_change_irq_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  pin_level_a: assert property ({terminal_ready_out_n, request_to_send_out_n} ==
    ({2{$past(rst_i | loopback_i)}} | ~$past({dtr_bit_i, rts_bit_i}))) else $error("pins");
  cts_state_a: assert property (msr_o[4] == ~$past(clear_to_send_in_n, 3))
    else $error("status bit wrong");
  msr_zero_a: assert property (msr_o[7:5] == 3'h0 && msr_o[3:1] == 3'h0)
    else $error("unused status bits set");
  delta_set_a: assert property ($past(clear_to_send_in_n, 4) != $past(clear_to_send_in_n, 5) |-> msr_o[0])
    else $error("delta not set");
  delta_clear_a: assert property (msr_read_i && $past(clear_to_send_in_n, 2) == $past(clear_to_send_in_n, 3)
    |-> ##2 !msr_o[0]) else $error("delta not cleared");
  irq_level_a: assert property (cts_change_irq_o == ($past(msi_enable_i) && msr_o[0]))
    else $error("interrupt level wrong");
endmodule // umcl_chk
bind umcl_modem_lines umcl_chk u_chk (.*);
`default_nettype wire

// *** bench/umcl_modem_lines_bench.sv ***
// modem line bench
`timescale 1ns/1ps
`default_nettype none
`define C(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module umcl_modem_lines_bench;
  logic ref_clk_i = 1'h0, rst_i = 1'h1, dtr_bit_i = 1'h1, rts_bit_i = 1'h1, loopback_i = 1'h0;
  logic msi_enable_i = 1'h1, msr_read_i = 1'h0, rdy = 1'h0;
  wire logic clear_to_send_in_n, terminal_ready_out_n, request_to_send_out_n, cts_change_irq_o;
  wire logic [7:0] msr_o;
  wire logic [10:0] st = {terminal_ready_out_n, request_to_send_out_n, cts_change_irq_o, msr_o};
  int n_errors, n_compared;
  always #5 ref_clk_i = ~ref_clk_i;
  umcl_modem u_mdm (.ref_clk_i, .ready_i(rdy), .clear_to_send_in_n);
  umcl_modem_lines u_dut (.*);
  task step(int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task final_report;
    $display("checks %0d fails %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // cycle ceiling well above the ~47 cycles the sequence needs
  initial begin
    step(200);
    n_errors++;
    final_report;
  end
  initial begin
    step(6);
    `C("reset", 11'h600, st)
    $display("reset test done");
    rst_i = 1'h0;
    for (int i = 0; i < 8; i++) begin
      {loopback_i, rts_bit_i, dtr_bit_i} = i[2:0];
      step(2);
      `C("pins", {2{loopback_i}} | ~{dtr_bit_i, rts_bit_i}, st[10:9])
    end
    $display("pins test done");
    rdy = 1'h1;
    step(6);
    `C("cts", 11'h711, st)
    msr_read_i = 1'h1;
    step(1);
    msr_read_i = 1'h0;
    step(3);
    `C("read", 11'h610, st)
    $display("cts test done");
    msi_enable_i = 1'h0;
    rdy = 1'h0;
    step(6);
    `C("masked", 11'h601, st)
    msi_enable_i = 1'h1;
    step(1);
    `C("unmask", 11'h701, st)
    loopback_i = 1'h0;
    msr_read_i = 1'h1;
    step(1);
    msr_read_i = 1'h0;
    step(3);
    `C("clear", 11'h000, st)
    $display("mask test done");
    rst_i = 1'h1;
    step(2);
    `C("mid reset", 11'h600, st)
    rst_i = 1'h0;
    step(2);
    `C("after reset", 11'h000, st)
    $display("mid-run reset test done");
    final_report;
  end
endmodule // umcl_modem_lines_bench
`default_nettype wire
